// [verilog/jesd_rx_ctrl_pkg.sv]
// constants and types for the receive link control registers
package jesd_rx_ctrl_pkg;

	// ----------------------------------------------------------------
	// register addresses (15-bit serial port address space)
	// ----------------------------------------------------------------
	localparam logic [14:0] ADDR_GENERAL = 15'h0300;
	localparam logic [14:0] ADDR_SUBCLASS = 15'h0301;
	localparam logic [14:0] ADDR_LATENCY0 = 15'h0302;
	localparam logic [14:0] ADDR_LATENCY1 = 15'h0303;
	localparam logic [14:0] ADDR_MFDELAY0 = 15'h0304;
	localparam logic [14:0] ADDR_MFDELAY1 = 15'h0305;
	localparam logic [14:0] ADDR_READOUT0 = 15'h0306;
	localparam logic [14:0] ADDR_READOUT1 = 15'h0307;

	// ----------------------------------------------------------------
	// field positions and masks
	// ----------------------------------------------------------------
	localparam int CHECKSUM_BIT = 6;
	localparam int TWO_LINK_BIT = 3;
	localparam int PAGE_BIT = 2;
	localparam int ENABLE_LSB = 0;
	localparam logic [7:0] GENERAL_WMASK = 8'h7f;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] GENERAL_RST = 8'h00;
	localparam logic [2:0] SUBCLASS_RST = 3'h1;
	localparam logic [4:0] LATENCY_RST = 5'h00;
	localparam logic [4:0] MFDELAY_RST = 5'h00;
	localparam logic [4:0] READOUT_RST = 5'h06;

	// ----------------------------------------------------------------
	// serial port framing
	// ----------------------------------------------------------------
	localparam logic [4:0] SPI_INSTR_BITS = 5'h10;
	localparam logic [4:0] SPI_FRAME_BITS = 5'h18;

	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic wr;
		logic [14:0] addr;
		logic [7:0] wdata;
	} spi_req_s;

	typedef struct packed {
		logic frameTick;
		logic localMf;
		logic globalMf;
	} link_in_s;

	typedef struct packed {
		logic active;
		logic delayedMf;
		logic readStrobe;
		logic [4:0] latency;
	} link_out_s;

	typedef struct packed {
		logic [2:0] sclkSync;
		logic [2:0] csbSync;
		logic [2:0] sdiSync;
		logic sclkF;
		logic csbF;
		logic [4:0] count;
		logic [15:0] shift;
		logic reading;
		logic loadPending;
		logic [7:0] outShift;
		logic outBit;
		spi_req_s req;
	} spi_state_s;

	typedef struct packed {
		logic [7:0] general;
		logic [2:0] subclass;
		logic [1:0][4:0] mfDelay;
		logic [1:0][4:0] readout;
		logic [1:0][4:0] latency;
		logic [1:0][4:0] mfPos;
		logic [1:0][31:0] hist;
		logic [1:0] delayedMf;
		logic [1:0] readStrobe;
		logic [7:0] csAcc;
		logic [7:0] checksum;
	} ctrl_state_s;

endpackage

// [verilog/spi_reg_port.sv]
// serial register port: 16-bit instruction, one data byte, msb first
`timescale 1ns/1ps
module spi_reg_port (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	// serial pins
	input wire logic sclk,
	input wire logic csb,
	input wire logic sdioIn,
	output logic sdioOut,
	output logic sdioOe_n,
	// register side
	output jesd_rx_ctrl_pkg::spi_req_s req,
	input wire logic [7:0] rdata
);
	import jesd_rx_ctrl_pkg::*;

	spi_state_s st;
	spi_state_s next_st;
	logic rise;
	logic fall;

	// ----------------------------------------------------------------
	// state update
	// ----------------------------------------------------------------
	always_comb begin
		next_st = st;
		next_st.req.wr = 1'b0;
		next_st.sclkSync = {st.sclkSync[1:0], sclk};
		next_st.csbSync = {st.csbSync[1:0], csb};
		next_st.sdiSync = {st.sdiSync[1:0], sdioIn};
		// change counts once second and third stage agree
		if (st.sclkSync[1] == st.sclkSync[2]) begin
			next_st.sclkF = st.sclkSync[2];
		end
		if (st.csbSync[1] == st.csbSync[2]) begin
			next_st.csbF = st.csbSync[2];
		end
		rise = (st.sclkSync[1] == st.sclkSync[2]) && st.sclkSync[2] && !st.sclkF;
		fall = (st.sclkSync[1] == st.sclkSync[2]) && !st.sclkSync[2] && st.sclkF;
		if (st.loadPending) begin
			next_st.outShift = rdata;
			next_st.loadPending = 1'b0;
		end
		if (st.csbF) begin
			next_st.count = 5'h00;
			next_st.reading = 1'b0;
		end else if (rise) begin
			if (st.count < SPI_INSTR_BITS) begin
				next_st.shift = {st.shift[14:0], st.sdiSync[2]};
				if (st.count == SPI_INSTR_BITS - 5'h01) begin
					next_st.req.addr = {st.shift[13:0], st.sdiSync[2]};
					next_st.reading = st.shift[14];
					next_st.loadPending = st.shift[14];
				end
			end else if (!st.reading && st.count < SPI_FRAME_BITS) begin
				next_st.shift = {st.shift[14:0], st.sdiSync[2]};
				if (st.count == SPI_FRAME_BITS - 5'h01) begin
					next_st.req.wdata = {st.shift[6:0], st.sdiSync[2]};
					next_st.req.wr = 1'b1;
				end
			end
			if (st.count != 5'h1f) begin
				next_st.count = st.count + 5'h01;
			end
		end else if (fall && st.reading && st.count >= SPI_INSTR_BITS) begin
			next_st.outBit = st.outShift[7];
			next_st.outShift = {st.outShift[6:0], 1'b0};
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st <= '0;
			st.sclkSync <= 3'h0;
			st.csbSync <= 3'h7;
			st.csbF <= 1'b1;
		end else if (ce) begin
			st <= next_st;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign req = st.req;
	assign sdioOut = st.outBit;
	assign sdioOe_n = !(st.reading && !st.csbF && st.count >= SPI_INSTR_BITS);

endmodule // spi_reg_port

// [verilog/jesd_rx_link_control_regs.sv]
// receive link control and status registers with per-link timing
`timescale 1ns/1ps
module jesd_rx_link_control_regs (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	// serial register port
	input wire logic sclk,
	input wire logic csb,
	input wire logic sdioIn,
	output logic sdioOut,
	output logic sdioOe_n,
	// link timing
	input wire jesd_rx_ctrl_pkg::link_in_s [1:0] linkIn,
	output jesd_rx_ctrl_pkg::link_out_s [1:0] linkOut,
	// configuration octets
	input wire logic cfgValid,
	input wire logic cfgStart,
	input wire logic cfgLast,
	input wire logic [7:0] cfgOctet,
	output logic [7:0] checksum,
	// configuration outputs
	output logic checksumMethod,
	output logic twoLinkMode,
	output logic linkPage,
	output logic [2:0] subclass
);
	import jesd_rx_ctrl_pkg::*;

	ctrl_state_s st;
	ctrl_state_s next_st;
	spi_req_s req;
	logic [7:0] rdata;
	logic [7:0] sumNow;
	logic [1:0] act;
	logic [4:0] posNow;
	logic dm;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [4:0] nextPos(input logic [4:0] p);
		return (p == 5'h1f) ? p : p + 5'h01;
	endfunction

	function automatic logic delayPick(input logic [31:0] h,
		input logic [4:0] d, input logic g);
		return (d == 5'h00) ? g : h[d - 5'h01];
	endfunction

	function automatic logic [7:0] regRead(input ctrl_state_s s,
		input logic [14:0] a);
		case (a)
			ADDR_GENERAL: regRead = s.general & GENERAL_WMASK;
			ADDR_SUBCLASS: regRead = {5'h00, s.subclass};
			ADDR_LATENCY0: regRead = {3'h0, s.latency[0]};
			ADDR_LATENCY1: regRead = {3'h0, s.latency[1]};
			ADDR_MFDELAY0: regRead = {3'h0, s.mfDelay[0]};
			ADDR_MFDELAY1: regRead = {3'h0, s.mfDelay[1]};
			ADDR_READOUT0: regRead = {3'h0, s.readout[0]};
			ADDR_READOUT1: regRead = {3'h0, s.readout[1]};
			default: regRead = 8'h00;
		endcase
	endfunction

	// ----------------------------------------------------------------
	// serial port
	// ----------------------------------------------------------------
	spi_reg_port port (
		.clk(clk),
		.rst_n(rst_n),
		.ce(ce),
		.sclk(sclk),
		.csb(csb),
		.sdioIn(sdioIn),
		.sdioOut(sdioOut),
		.sdioOe_n(sdioOe_n),
		.req(req),
		.rdata(rdata)
	);

	assign rdata = regRead(st, req.addr);

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		next_st = st;
		act[0] = st.general[ENABLE_LSB];
		// link 1 gated by dual mode
		act[1] = st.general[ENABLE_LSB + 1] && st.general[TWO_LINK_BIT];
		posNow = 5'h00;
		dm = 1'b0;
		// both enables land from one write
		if (req.wr) begin
			case (req.addr)
				ADDR_GENERAL: next_st.general = req.wdata & GENERAL_WMASK;
				ADDR_SUBCLASS: next_st.subclass = req.wdata[2:0];
				ADDR_MFDELAY0: next_st.mfDelay[0] = req.wdata[4:0];
				ADDR_MFDELAY1: next_st.mfDelay[1] = req.wdata[4:0];
				ADDR_READOUT0: next_st.readout[0] = req.wdata[4:0];
				ADDR_READOUT1: next_st.readout[1] = req.wdata[4:0];
				default: next_st.general = st.general;
			endcase
		end
		for (int i = 0; i < 2; i++) begin
			next_st.readStrobe[i] = 1'b0;
			next_st.delayedMf[i] = 1'b0;
			if (!act[i]) begin
				next_st.hist[i] = 32'h0;
				next_st.mfPos[i] = 5'h00;
				next_st.latency[i] = LATENCY_RST;
			end else if (linkIn[i].frameTick) begin
				dm = delayPick(st.hist[i], st.mfDelay[i], linkIn[i].globalMf);
				next_st.hist[i] = {st.hist[i][30:0], linkIn[i].globalMf};
				posNow = dm ? 5'h00 : nextPos(st.mfPos[i]);
				next_st.mfPos[i] = posNow;
				next_st.delayedMf[i] = dm;
				next_st.readStrobe[i] = (posNow == st.readout[i]);
				if (linkIn[i].localMf) begin
					next_st.latency[i] = posNow;
				end
			end
		end
		sumNow = (cfgStart ? 8'h00 : st.csAcc) + cfgOctet;
		if (cfgValid) begin
			next_st.csAcc = sumNow;
			if (cfgLast) begin
				next_st.checksum = st.general[CHECKSUM_BIT] ? sumNow : 8'h00;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st <= '0;
			st.general <= GENERAL_RST;
			st.subclass <= SUBCLASS_RST;
			st.mfDelay <= {MFDELAY_RST, MFDELAY_RST};
			st.readout <= {READOUT_RST, READOUT_RST};
		end else if (ce) begin
			st <= next_st;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			linkOut[i].active = act[i];
			linkOut[i].delayedMf = st.delayedMf[i];
			linkOut[i].readStrobe = st.readStrobe[i];
			linkOut[i].latency = st.latency[i];
		end
	end

	assign checksum = st.checksum;
	assign checksumMethod = st.general[CHECKSUM_BIT];
	assign twoLinkMode = st.general[TWO_LINK_BIT];
	assign linkPage = st.general[PAGE_BIT];
	assign subclass = st.subclass;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	logic genWr;
	assign genWr = ce && req.wr && req.addr == ADDR_GENERAL;

	checksum_sum_a: assert property (@(posedge clk) disable iff (!rst_n)
		ce && cfgValid && cfgLast && checksumMethod |=> checksum == $past(sumNow))
		else $error("checksum is not the octet sum");
	mode_bit_a: assert property (@(posedge clk) disable iff (!rst_n)
		genWr |=> twoLinkMode == $past(req.wdata[3]))
		else $error("dual link mode bit not taken");
	page_bit_a: assert property (@(posedge clk) disable iff (!rst_n)
		genWr |=> linkPage == $past(req.wdata[2]))
		else $error("page select bit not taken");
	idle_link_a: assert property (@(posedge clk) disable iff (!rst_n)
		!linkOut[0].active |=> !linkOut[0].readStrobe && !linkOut[0].delayedMf)
		else $error("idle link produced timing");
	enable_map_a: assert property (@(posedge clk) disable iff (!rst_n)
		genWr |=> linkOut[0].active == $past(req.wdata[0]))
		else $error("link 0 enable mapping wrong");
	link1_dual_a: assert property (@(posedge clk) disable iff (!rst_n)
		linkOut[1].active |-> twoLinkMode && st.general[1])
		else $error("link 1 active outside dual mode");
	joint_enable_a: assert property (@(posedge clk) disable iff (!rst_n)
		genWr && req.wdata[3] && req.wdata[1:0] == 2'h3
		|=> linkOut[0].active && linkOut[1].active)
		else $error("joint enable failed");
	latency_capture_a: assert property (@(posedge clk) disable iff (!rst_n)
		ce && act[0] && linkIn[0].frameTick && linkIn[0].localMf
		|=> linkOut[0].latency == st.mfPos[0])
		else $error("latency not captured");
	zero_delay_a: assert property (@(posedge clk) disable iff (!rst_n)
		ce && act[0] && linkIn[0].frameTick && linkIn[0].globalMf
		&& st.mfDelay[0] == 5'h00 |=> linkOut[0].delayedMf)
		else $error("undelayed multiframe missing");
	readout_point_a: assert property (@(posedge clk) disable iff (!rst_n)
		linkOut[0].readStrobe |-> st.mfPos[0] == $past(st.readout[0]))
		else $error("read-out at wrong position");
	subclass_write_a: assert property (@(posedge clk) disable iff (!rst_n)
		ce && req.wr && req.addr == ADDR_SUBCLASS
		|=> subclass == $past(req.wdata[2:0]))
		else $error("subclass field not written");
	reserved_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
		rdata[7] == 1'b0 && (req.addr == ADDR_GENERAL || rdata[6:5] == 2'h0))
		else $error("reserved bits read nonzero");

	both_links_c: cover property (@(posedge clk) disable iff (!rst_n)
		linkOut[0].active && linkOut[1].active);
	readout1_c: cover property (@(posedge clk) disable iff (!rst_n)
		linkOut[1].readStrobe);
	checksum_c: cover property (@(posedge clk) disable iff (!rst_n)
		ce && cfgValid && cfgLast && checksumMethod);

endmodule // jesd_rx_link_control_regs

// [verif/link_timing_model.sv]
// far-side frame and multiframe timing source for both receive links
`timescale 1ns/1ps
module link_timing_model #(
	parameter int FRAME_CLKS = 3,
	parameter int MF_FRAMES = 20,
	parameter int LOCAL_OFS = 5
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// timing pulses
	output jesd_rx_ctrl_pkg::link_in_s [1:0] linkIn
);
	import jesd_rx_ctrl_pkg::*;
	int clkCnt;
	int frameCnt;

	// ----------------------------------------------------------------
	// frame and multiframe counters, moved on the falling edge
	// ----------------------------------------------------------------
	always @(negedge clk or negedge rst_n) begin
		if (!rst_n) begin
			clkCnt <= 0;
			frameCnt <= 0;
		end else begin
			clkCnt <= (clkCnt == FRAME_CLKS - 1) ? 0 : clkCnt + 1;
			if (clkCnt == FRAME_CLKS - 1)
				frameCnt <= (frameCnt == MF_FRAMES - 1) ? 0 : frameCnt + 1;
		end
	end

	// link 1 local multiframe sits two frames later than link 0
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			linkIn[i].frameTick = (clkCnt == 0);
			linkIn[i].globalMf = (frameCnt == 0);
			linkIn[i].localMf = (frameCnt == LOCAL_OFS + 2 * i);
		end
	end
endmodule // link_timing_model

// [verif/jesd_rx_link_control_regs_bench.sv]
// self-checking bench for the receive link control registers
`timescale 1ns/1ps
module jesd_rx_link_control_regs_bench;
	import jesd_rx_ctrl_pkg::*;
	logic clk = 0, rst_n = 0, ce = 1, sclk = 0, csb = 1, sdioDrv = 0;
	logic cfgValid = 0, cfgStart = 0, cfgLast = 0;
	logic [7:0] cfgOctet = 8'h00;
	logic sdioOut, sdioOe_n, checksumMethod, twoLinkMode, linkPage;
	logic [7:0] checksum;
	logic [2:0] subclass;
	link_in_s [1:0] linkIn;
	link_out_s [1:0] linkOut;
	wire logic sdioWire = sdioOe_n ? sdioDrv : sdioOut;
	int mismatches = 0, checksDone = 0, cycles = 0, seed = 73640;
	int pos[2], gcnt[2], seenMf = 0, seenRd = 0;
	logic [4:0] expLat[2], delay[2], rdpt[2];
	bit lmPend[2], tickPrev[2];

	always #12.5 clk = ~clk;

	jesd_rx_link_control_regs dut (.clk, .rst_n, .ce, .sclk, .csb,
		.sdioIn(sdioWire), .sdioOut, .sdioOe_n, .linkIn, .linkOut,
		.cfgValid, .cfgStart, .cfgLast, .cfgOctet, .checksum,
		.checksumMethod, .twoLinkMode, .linkPage, .subclass);

	link_timing_model partner (.clk, .rst_n, .linkIn);

	// ----------------------------------------------------------------
	// compare, verdict, serial frames
	// ----------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checksDone++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic summarize();
		if (mismatches == 0 && checksDone > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// msb first; read bits sampled late in the low phase
	task automatic xfer(input logic rd, input logic [14:0] a,
		input logic [7:0] wd, output logic [7:0] rv);
		logic [23:0] f;
		f = {rd, a, wd};
		rv = 8'h00;
		@(negedge clk);
		csb = 0;
		for (int i = 23; i >= 0; i--) begin
			@(negedge clk);
			sclk = 0;
			sdioDrv = f[i];
			repeat (7) @(negedge clk);
			if (i < 8)
				rv[i] = sdioWire;
			sclk = 1;
			repeat (4) @(negedge clk);
		end
		repeat (6) @(negedge clk);
		sclk = 0;
		repeat (6) @(negedge clk);
		csb = 1;
		repeat (8) @(negedge clk);
	endtask

	// links idle before their timing is reprogrammed
	task automatic prog();
		logic [7:0] r;
		xfer(0, ADDR_GENERAL, 8'h00, r);
		for (int i = 0; i < 2; i++) begin
			delay[i] = 5'($unsigned($random(seed)) % 20);
			rdpt[i] = 5'($unsigned($random(seed)) % 11);
			xfer(0, ADDR_MFDELAY0 + 15'(i), {3'h0, delay[i]}, r);
			xfer(0, ADDR_READOUT0 + 15'(i), {3'h0, rdpt[i]}, r);
		end
	endtask

	task automatic sum_check(input logic meth);
		logic [7:0] s, o;
		int n;
		n = 1 + ($unsigned($random(seed)) % 8);
		s = 8'h00;
		for (int i = 0; i < n; i++) begin
			o = $random(seed);
			s += o;
			@(negedge clk);
			cfgValid = 1;
			cfgStart = (i == 0);
			cfgLast = (i == n - 1);
			cfgOctet = o;
		end
		@(negedge clk);
		cfgValid = 0;
		cfgLast = 0;
		repeat (3) @(negedge clk);
		chk(checksum, meth ? s : 8'h00);
	endtask

	// ----------------------------------------------------------------
	// link timing monitor
	// ----------------------------------------------------------------
	// delayed pulse restarts the position before strobe and latency use it
	always @(posedge clk) begin
		for (int i = 0; i < 2; i++) begin
			if (!linkOut[i].active) begin
				pos[i] = 0;
				expLat[i] = 5'h00;
				lmPend[i] = 0;
				tickPrev[i] = 0;
			end else begin
				if (linkOut[i].delayedMf) begin
					chk(gcnt[i], delay[i]);
					seenMf++;
					pos[i] = 0;
				end
				if (tickPrev[i]) begin
					chk(linkOut[i].readStrobe, pos[i] == rdpt[i]);
					if (linkOut[i].readStrobe)
						seenRd++;
				end
				if (lmPend[i])
					expLat[i] = 5'(pos[i]);
				lmPend[i] = linkIn[i].frameTick && linkIn[i].localMf;
				tickPrev[i] = linkIn[i].frameTick;
				if (linkIn[i].frameTick)
					chk(linkOut[i].latency, expLat[i]);
				if (linkIn[i].frameTick && pos[i] < 31)
					pos[i]++;
			end
			if (linkIn[i].frameTick)
				gcnt[i] = linkIn[i].globalMf ? 0 : gcnt[i] + 1;
		end
	end

	always @(posedge clk) begin
		cycles++;
		if (cycles == 70000) begin
			mismatches++;
			summarize();
		end
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	logic [7:0] rstv[8] = '{8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h06, 8'h06};
	logic [7:0] wv[8] = '{8'h00, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
		8'hea, 8'hea};
	logic [7:0] rdv[8] = '{8'h00, 8'h07, 8'h00, 8'h00, 8'h1f, 8'h1f,
		8'h0a, 8'h0a};

	initial begin
		logic [7:0] r, g;
		repeat (2) @(negedge clk);
		rst_n = 1;
		repeat (4) @(negedge clk);
		chk(subclass, 3'h1);
		for (int i = 0; i < 8; i++) begin
			xfer(1, ADDR_GENERAL + 15'(i), 8'h00, r);
			chk(r, rstv[i]);
		end
		for (int i = 1; i < 8; i++) begin
			xfer(0, ADDR_GENERAL + 15'(i), wv[i], r);
			xfer(1, ADDR_GENERAL + 15'(i), 8'h00, r);
			chk(r, rdv[i]);
		end
		xfer(0, 15'h0310, 8'h5a, r);
		xfer(1, 15'h0310, 8'h00, r);
		chk(r, 8'h00);
		for (int k = 0; k < 16; k++) begin
			prog();
			g = $random(seed);
			g[3:0] = {k[2], g[2], k[1:0]};
			xfer(0, ADDR_GENERAL, g, r);
			xfer(1, ADDR_GENERAL, 8'h00, r);
			chk(r, g & 8'h7f);
			chk({checksumMethod, twoLinkMode, linkPage}, {g[6], g[3], g[2]});
			chk({linkOut[1].active, linkOut[0].active}, {g[1] & g[3], g[0]});
			repeat (300) @(negedge clk);
		end
		prog();
		xfer(0, ADDR_GENERAL, 8'h09, r);
		chk(linkOut[0].active, 1'b1);
		xfer(0, ADDR_GENERAL, 8'h0b, r);
		chk({linkOut[1].active, linkOut[0].active}, 2'h3);
		for (int k = 0; k < 6; k++) begin
			xfer(0, ADDR_GENERAL, {1'b0, k[0], 6'h0b}, r);
			sum_check(k[0]);
		end
		@(negedge clk);
		rst_n = 0;
		repeat (2) @(negedge clk);
		rst_n = 1;
		repeat (4) @(negedge clk);
		xfer(1, ADDR_READOUT1, 8'h00, r);
		chk(r, 8'h06);
		// nothing moves while the clock enable is low
		xfer(0, ADDR_GENERAL, 8'h40, r);
		ce = 0;
		xfer(0, ADDR_SUBCLASS, 8'h00, r);
		@(negedge clk);
		cfgValid = 1;
		cfgStart = 1;
		cfgLast = 1;
		cfgOctet = 8'h5a;
		@(negedge clk);
		cfgValid = 0;
		cfgStart = 0;
		cfgLast = 0;
		ce = 1;
		repeat (4) @(negedge clk);
		chk(checksum, 8'h00);
		xfer(1, ADDR_SUBCLASS, 8'h00, r);
		chk(r, 8'h01);
		chk(seenMf != 0 && seenRd != 0, 1'b1);
		summarize();
	end
endmodule // jesd_rx_link_control_regs_bench
